// file: bench/pace_source_model.sv
/* External pacing source on one pin.
   Assumes go is raised by the bench to start a burst. */
`default_nettype none
module pace_source_model (
  input  wire logic clk,
  input  wire logic go,
  output var  logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  // Wide spacing so each sample finishes first
  initial begin
    line = 1'b0;
    forever begin
      @(posedge go);
      repeat (4) begin
        repeat (10) @(posedge clk);
        line <= 1'b1;
        repeat (2) @(posedge clk);
        line <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
/* Bench for the timing engine.
   Assumes the pacing model on pin 3. */
`default_nettype none
`include "timing_engine_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, srst, go, m_line, pb;
  wire  [15:0] pin_in = {12'h000, m_line, 3'h0};
  logic [15:0] pin_out, pin_oe_n, pace_delay, pace_period;
  logic [15:0] conv_delay, conv_period;
  logic [7:0]  bus_in, bus_out, bus_oe_n, channel_count;
  logic [3:0]  pace_src_sel, tb_src_sel, conv_src_sel;
  logic [4:0]  pace_ext_index, tb_ext_index, conv_ext_index;
  logic [4:0]  pace_route, start_route;
  logic [31:0] pre_count, post_count, samples_left;
  logic star_in, compare_event, backplane_clk_in, counter_output, sw_start;
  logic sw_stop, sw_pace, hw_start, ref_trigger, pause_level;
  logic pause_active_high, start_is_software, finite_mode, pretrigger_mode;
  logic pace_falling, tb_falling, conv_falling, conv_tb_is_20mhz;
  logic pace_level_mode, acq_running, in_sample, conversion_start;
  logic sample_start, start_pulse, acq_done, post_phase;
  int   err_count = 0, check_count = 0, ns = 0, nc = 0, nb = 0;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  analog_input_timing_engine i_dut (.*);
  pace_source_model i_src (.clk(clk), .go(go), .line(m_line));
  // ==========
  // Event tallies, bus line 0 counted on rising edges
  always @(posedge clk) begin
    pb <= bus_out[0];
    ns <= ns + int'(sample_start);
    nc <= nc + int'(conversion_start);
    nb <= nb + int'(bus_out[0] && !pb);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One-cycle pulses: stop, start, pace, strobe
  task automatic kick(input logic [3:0] v);
    @(posedge clk) {sw_stop, sw_start, sw_pace, counter_output} <= v;
    @(posedge clk) {sw_stop, sw_start, sw_pace, counter_output} <= 4'h0;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 200 && acq_running !== 1'b0; i++) @(posedge clk);
    if (acq_running !== 1'b0) begin
      err_count++;
      test_done;
    end
  endtask
  // Finite post-triggered run, software pacing, two strobes a sample
  task automatic t_post;
    int s0, c0;
    s0 = ns;
    c0 = nc;
    kick(4'h1);
    kick(4'h2);
    repeat (4) @(posedge clk);
    chk(ns - s0, 0);
    chk(nc - c0, 0);
    kick(4'h4);
    @(posedge clk);
    chk(start_pulse, 1'b1);
    repeat (2) @(posedge clk);
    chk(samples_left, 32'h3);
    for (int k = 0; k < 3; k++) begin
      kick(4'h2);
      kick(4'h2);
      kick(4'h1);
      kick(4'h1);
      kick(4'h1);
    end
    wait_idle;
    chk(ns - s0, 3);
    chk(nc - c0, 6);
    chk(samples_left, 32'h0);
  endtask
  // External pin pacing, pause, route to bus line 0
  task automatic t_ext;
    int s0, b0;
    @(posedge clk);
    {pace_src_sel, conv_src_sel} <= {`PACE_SRC_PIN, `CONV_SRC_TIMEBASE};
    {channel_count, finite_mode, post_count} <= {8'h01, 1'b0, 32'h10};
    {pace_route, pause_level} <= {`ROUTE_BUS_BASE, 1'b1};
    kick(4'h4);
    repeat (3) @(posedge clk);
    chk(bus_oe_n[0], 1'b0);
    chk(pin_oe_n, 16'hFFFF);
    s0 = ns;
    b0 = nb;
    go <= 1'b1;
    repeat (60) @(posedge clk);
    chk(ns - s0, 0);
    {go, pause_level} <= 2'b00;
    @(posedge clk) go <= 1'b1;
    repeat (60) @(posedge clk);
    chk(ns - s0, 4);
    chk(nb - b0, 4);
    kick(4'h8);
    wait_idle;
  endtask
  // Pre-triggered finite run: early reference ignored, later one arms post
  task automatic t_pre;
    int s0;
    s0 = ns;
    @(posedge clk);
    {pace_src_sel, conv_src_sel} <= {`PACE_SRC_SOFTWARE, `CONV_SRC_COUNTER};
    {pretrigger_mode, finite_mode} <= 2'b11;
    {channel_count, post_count} <= {8'h01, 32'h3};
    kick(4'h4);
    ref_trigger <= 1'b1;
    repeat (6) @(posedge clk);
    ref_trigger <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      kick(4'h2);
      kick(4'h1);
    end
    chk(post_phase, 1'b0);
    ref_trigger <= 1'b1;
    repeat (6) @(posedge clk);
    chk(post_phase, 1'b1);
    chk(samples_left, 32'h3);
    for (int k = 0; k < 3; k++) begin
      kick(4'h2);
      kick(4'h1);
    end
    wait_idle;
    chk(ns - s0, 5);
    ref_trigger <= 1'b0;
  endtask
  initial begin
    {srst, go, sw_start, sw_stop, sw_pace, counter_output} = 6'h20;
    {star_in, compare_event, backplane_clk_in, hw_start, ref_trigger} = 5'h0;
    {pause_level, pretrigger_mode, pace_falling, tb_falling} = 4'h0;
    {conv_falling, pace_level_mode, bus_in} = 10'h000;
    {pause_active_high, start_is_software, finite_mode} = 3'h7;
    conv_tb_is_20mhz = 1'b1;
    pace_src_sel = `PACE_SRC_SOFTWARE;
    tb_src_sel = `TB_SRC_20MHZ;
    conv_src_sel = `CONV_SRC_COUNTER;
    {pace_ext_index, tb_ext_index, conv_ext_index} = 15'h0C00;
    {pace_delay, pace_period} = {`PACE_DELAY_DEFAULT, 16'h0004};
    {conv_delay, conv_period} = {`CONV_DELAY_DEFAULT, 16'h0001};
    {channel_count, pre_count, post_count} = {8'h02, 32'h2, 32'h3};
    {pace_route, start_route} = {`ROUTE_NONE, `ROUTE_NONE};
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(pin_oe_n, 16'hFFFF);
    t_post;
    t_ext;
    t_pre;
    test_done;
  end
endmodule
`default_nettype wire

// file: bench/timing_engine_assertions.sv
/* Port checker for the timing engine.
   Assumes binding into analog_input_timing_engine. */
`default_nettype none
module timing_engine_assertions (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        sw_start,
  input wire logic        hw_start,
  input wire logic        sw_stop,
  input wire logic        finite_mode,
  input wire logic        acq_running,
  input wire logic        in_sample,
  input wire logic        conversion_start,
  input wire logic        sample_start,
  input wire logic        acq_done,
  input wire logic [31:0] samples_left,
  input wire logic        post_phase
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ==========
  // Run state stays low for two cycles after a stop or the end
  sequence s_halt;
    !acq_running ##1 !acq_running;
  endsequence
  a_idle_gate: assert property (sample_start |-> $past(acq_running))
    else $error("sample while idle");
  a_one_sample: assert property (sample_start |-> !$past(in_sample))
    else $error("pacing accepted inside a sample");
  a_sample_open: assert property (sample_start |-> in_sample)
    else $error("sample not opened");
  a_conv_gate: assert property (conversion_start |-> $past(in_sample))
    else $error("strobe outside a sample");
  a_run_cause: assert property ($rose(acq_running) |->
    $past(sw_start || hw_start))
    else $error("run without start");
  a_stop_halt: assert property (sw_stop |=> s_halt)
    else $error("stop ignored");
  a_done_halt: assert property (acq_done && !$past(sw_stop) |->
    $past(finite_mode) ##0 s_halt)
    else $error("done without halt");
  // Post phase counts down by one only
  a_count_step: assert property (acq_running && $past(acq_running)
    && post_phase && $past(post_phase) && samples_left != $past(samples_left)
    |-> samples_left == $past(samples_left) - 32'h1)
    else $error("bad count step");
endmodule
bind analog_input_timing_engine timing_engine_assertions i_chk (.*);
`default_nettype wire

// file: pkg/timing_engine_defines.vh
/*
  Constants for the analog input timing engine: source selector codes,
  route codes, default delays and clock rates.
  Assumes inclusion by bare name from rtl files.
*/
`ifndef TIMING_ENGINE_DEFINES_VH
`define TIMING_ENGINE_DEFINES_VH

// =====================================================================
// Pacing clock source selectors (4 bits)
`define PACE_SRC_COUNTER    4'h0
`define PACE_SRC_TIMEBASE   4'h1
`define PACE_SRC_SOFTWARE   4'h2
`define PACE_SRC_PIN        4'h3
`define PACE_SRC_BUS        4'h4
`define PACE_SRC_STAR       4'h5
`define PACE_SRC_COMPARE    4'h6

// =====================================================================
// Timebase source selectors (4 bits)
`define TB_SRC_20MHZ        4'h0
`define TB_SRC_100KHZ       4'h1
`define TB_SRC_BACKPLANE    4'h2
`define TB_SRC_BUS          4'h3
`define TB_SRC_PIN          4'h4
`define TB_SRC_STAR         4'h5
`define TB_SRC_COMPARE      4'h6

// =====================================================================
// Conversion strobe source selectors (4 bits)
`define CONV_SRC_TIMEBASE   4'h0
`define CONV_SRC_COUNTER    4'h1
`define CONV_SRC_PIN        4'h2
`define CONV_SRC_BUS        4'h3
`define CONV_SRC_STAR       4'h4
`define CONV_SRC_COMPARE    4'h5

// =====================================================================
// Route selectors: 0..15 pins, 16..23 bus lines, 31 = none
`define ROUTE_NONE          5'h1F
`define ROUTE_BUS_BASE      5'h10

// =====================================================================
// Default delays in timebase ticks
`define PACE_DELAY_DEFAULT  16'h0002
`define CONV_DELAY_DEFAULT  16'h0003

// Internal timebase rates derived from the 50 MHz system clock
`define CLK_HZ              50000000
`define TB_20MHZ_HZ         20000000
`define TB_100KHZ_HZ        100000

`endif

// file: rtl/analog_input_timing_engine.v
/*
  Analog input timing engine: pacing clock, conversion strobe, sample
  counting for post- and pre-triggered acquisition, pause and routing.
  Assumes external pins are asynchronous; config is static while busy.
*/
`default_nettype none

`include "timing_engine_defines.vh"

module analog_input_timing_engine #(
  parameter CW = 16,
  parameter NCH_W = 8
) (
  input  wire             clk,
  input  wire             srst,
  // External lines
  input  wire [15:0]      pin_in,
  output reg  [15:0]      pin_out,
  output reg  [15:0]      pin_oe_n,
  input  wire [7:0]       bus_in,
  output reg  [7:0]       bus_out,
  output reg  [7:0]       bus_oe_n,
  input  wire             star_in,
  input  wire             compare_event,
  input  wire             backplane_clk_in,
  input  wire             counter_output,
  // Control
  input  wire             sw_start,
  input  wire             sw_stop,
  input  wire             sw_pace,
  input  wire             hw_start,
  input  wire             ref_trigger,
  input  wire             pause_level,
  input  wire             pause_active_high,
  input  wire             start_is_software,
  input  wire             finite_mode,
  input  wire             pretrigger_mode,
  // Configuration
  input  wire [3:0]       pace_src_sel,
  input  wire [4:0]       pace_ext_index,
  input  wire             pace_falling,
  input  wire [3:0]       tb_src_sel,
  input  wire [4:0]       tb_ext_index,
  input  wire             tb_falling,
  input  wire [3:0]       conv_src_sel,
  input  wire [4:0]       conv_ext_index,
  input  wire             conv_falling,
  input  wire             conv_tb_is_20mhz,
  input  wire [CW-1:0]    pace_delay,
  input  wire [CW-1:0]    pace_period,
  input  wire [CW-1:0]    conv_delay,
  input  wire [CW-1:0]    conv_period,
  input  wire [NCH_W-1:0] channel_count,
  input  wire [31:0]      pre_count,
  input  wire [31:0]      post_count,
  input  wire [4:0]       pace_route,
  input  wire             pace_level_mode,
  input  wire [4:0]       start_route,
  // Status and results
  output reg              acq_running,
  output reg              in_sample,
  output reg              conversion_start,
  output reg              sample_start,
  output reg              start_pulse,
  output reg              acq_done,
  output reg  [31:0]      samples_left,
  output reg              post_phase
);

  localparam ST_IDLE = 2'h0;
  localparam ST_PRE  = 2'h1;
  localparam ST_ARM  = 2'h2;
  localparam ST_POST = 2'h3;

  // Ratios are small; slice them to the counter widths on purpose
  localparam integer DIV20_I   = `CLK_HZ / `TB_20MHZ_HZ;
  localparam integer DIV100K_I = `CLK_HZ / `TB_100KHZ_HZ;
  localparam [7:0]   DIV20     = DIV20_I[7:0];
  localparam [15:0]  DIV100K   = DIV100K_I[15:0];

  // =====================================================================
  // Line selection helper
  function pick_line;
    input [15:0] pins;
    input [7:0]  bus;
    input [4:0]  idx;
    begin
      if (idx[4])
        pick_line = bus[idx[2:0]];
      else
        pick_line = pins[idx[3:0]];
    end
  endfunction

  // Latched configuration
  reg [3:0]       c_pace_src;
  reg [4:0]       c_pace_idx;
  reg             c_pace_fall;
  reg [3:0]       c_tb_src;
  reg [4:0]       c_tb_idx;
  reg             c_tb_fall;
  reg [3:0]       c_conv_src;
  reg [4:0]       c_conv_idx;
  reg             c_conv_fall;
  reg             c_conv_20;
  reg [NCH_W-1:0] c_nch;
  reg             c_finite;
  reg [4:0]       c_route;
  reg             c_level;

  reg [1:0]       state;
  reg [1:0]       next_state;
  reg [NCH_W-1:0] conv_done;
  reg [15:0]      tb100_cnt;
  reg [7:0]       tb20_cnt;
  reg             tick_20;
  reg             tick_100k;
  reg             pause_meta;
  reg             pause_sync;
  reg             ref_meta;
  reg             ref_sync;
  reg             ref_prev;

  wire start_req;
  wire tb_raw;
  wire tb_tick;
  wire pace_raw;
  wire pace_edge;
  wire conv_raw;
  wire conv_edge;
  wire conv_tb_tick;
  wire pace_div;
  wire conv_div;
  wire paused;
  wire ref_edge;
  wire pace_accept;
  wire conv_accept;
  wire last_conv;
  wire pace_internal;
  wire stop_all;

  // =====================================================================
  // Internal 20 MHz and 100 kHz tick generators from clk
  always @(posedge clk) begin
    if (srst) begin
      tb20_cnt  <= 8'h00;
      tb100_cnt <= 16'h0000;
      tick_20   <= 1'b0;
      tick_100k <= 1'b0;
    end else begin
      // 50 MHz cannot pace 20 MHz exactly; integer divide by 2 gives ticks at 25 MHz
      tick_20   <= (tb20_cnt == 8'h00);
      tick_100k <= (tb100_cnt == 16'h0000);
      tb20_cnt  <= (tb20_cnt >= DIV20 - 8'h01) ? 8'h00 : tb20_cnt + 8'h01;
      tb100_cnt <= (tb100_cnt >= DIV100K - 16'h0001) ? 16'h0000 :
                   tb100_cnt + 16'h0001;
    end
  end

  // =====================================================================
  // Timebase source mux; never routed to a pin
  assign tb_raw = (c_tb_src == `TB_SRC_BACKPLANE) ? backplane_clk_in :
                  (c_tb_src == `TB_SRC_BUS) ? bus_in[c_tb_idx[2:0]] :
                  (c_tb_src == `TB_SRC_PIN) ? pin_in[c_tb_idx[3:0]] :
                  (c_tb_src == `TB_SRC_STAR) ? star_in :
                  (c_tb_src == `TB_SRC_COMPARE) ? compare_event :
                  1'b0;

  wire tb_tick_ext;
  edge_pick u_tb_edge (
    .clk         (clk),
    .srst        (srst),
    .level_in    (tb_raw),
    .use_falling (c_tb_fall),
    .bypass_sync (1'b0),
    .edge_pulse  (tb_tick_ext)
  );
  assign tb_tick = (c_tb_src == `TB_SRC_20MHZ) ? tick_20 :
                   (c_tb_src == `TB_SRC_100KHZ) ? tick_100k :
                   tb_tick_ext;

  assign conv_tb_tick = c_conv_20 ? tick_20 : tb_tick;

  // =====================================================================
  // Pause and reference synchronisers
  always @(posedge clk) begin
    if (srst) begin
      pause_meta <= 1'b0;
      pause_sync <= 1'b0;
      ref_meta   <= 1'b0;
      ref_sync   <= 1'b0;
      ref_prev   <= 1'b0;
    end else begin
      pause_meta <= pause_level;
      pause_sync <= pause_meta;
      ref_meta   <= ref_trigger;
      ref_sync   <= ref_meta;
      ref_prev   <= ref_sync;
    end
  end
  assign paused   = pause_sync == pause_active_high;
  assign ref_edge = ref_sync & ~ref_prev;

  // =====================================================================
  // Start and stop
  assign start_req = (state == ST_IDLE) && (sw_start || hw_start);
  assign stop_all  = sw_stop || (next_state == ST_IDLE && state != ST_IDLE);
  assign pace_internal = (c_pace_src == `PACE_SRC_TIMEBASE);

  // Pacing divider, started by the start trigger
  tick_divider #(.WIDTH(CW)) u_pace_div (
    .clk         (clk),
    .srst        (srst),
    .start       (start_req),
    .stop        (stop_all),
    .tick        (tb_tick),
    .first_delay (pace_delay),
    .period      (pace_period),
    .running     (),
    .out_pulse   (pace_div)
  );

  // =====================================================================
  // Pacing source mux
  assign pace_raw = (c_pace_src == `PACE_SRC_PIN) ?
                      pick_line(pin_in, bus_in, {1'b0, c_pace_idx[3:0]}) :
                    (c_pace_src == `PACE_SRC_BUS) ?
                      pick_line(pin_in, bus_in, {1'b1, c_pace_idx[3:0]}) :
                    (c_pace_src == `PACE_SRC_STAR) ? star_in :
                    (c_pace_src == `PACE_SRC_COMPARE) ? compare_event :
                    1'b0;

  wire pace_ext_edge;
  edge_pick u_pace_edge (
    .clk         (clk),
    .srst        (srst),
    .level_in    (pace_raw),
    .use_falling (c_pace_fall),
    .bypass_sync (1'b0),
    .edge_pulse  (pace_ext_edge)
  );

  wire cnt_pace_edge;
  edge_pick u_cnt_edge (
    .clk         (clk),
    .srst        (srst),
    .level_in    (counter_output),
    .use_falling (c_pace_fall),
    .bypass_sync (1'b1),
    .edge_pulse  (cnt_pace_edge)
  );

  assign pace_edge = pace_internal ? pace_div :
                     (c_pace_src == `PACE_SRC_SOFTWARE) ? sw_pace :
                     (c_pace_src == `PACE_SRC_COUNTER) ? cnt_pace_edge :
                     pace_ext_edge;

  // Gating: running, not paused, previous sample complete
  // Also refused on a stop and once a finite post phase is spent
  assign pace_accept = pace_edge && acq_running && !paused
                       && !in_sample && !sw_stop
                       && !(c_finite && state == ST_POST
                            && samples_left == 32'h0000_0000);

  // =====================================================================
  // Conversion strobe generation
  tick_divider #(.WIDTH(CW)) u_conv_div (
    .clk         (clk),
    .srst        (srst),
    .start       (pace_accept),
    .stop        (!in_sample && !pace_accept),
    .tick        (conv_tb_tick),
    .first_delay (conv_delay),
    .period      (conv_period),
    .running     (),
    .out_pulse   (conv_div)
  );

  assign conv_raw = (c_conv_src == `CONV_SRC_PIN) ?
                      pick_line(pin_in, bus_in, {1'b0, c_conv_idx[3:0]}) :
                    (c_conv_src == `CONV_SRC_BUS) ?
                      pick_line(pin_in, bus_in, {1'b1, c_conv_idx[3:0]}) :
                    (c_conv_src == `CONV_SRC_STAR) ? star_in :
                    (c_conv_src == `CONV_SRC_COMPARE) ? compare_event :
                    1'b0;

  wire conv_ext_edge;
  edge_pick u_conv_edge (
    .clk         (clk),
    .srst        (srst),
    .level_in    (conv_raw),
    .use_falling (c_conv_fall),
    .bypass_sync (1'b0),
    .edge_pulse  (conv_ext_edge)
  );

  wire cnt_conv_edge;
  edge_pick u_cnt_conv (
    .clk         (clk),
    .srst        (srst),
    .level_in    (counter_output),
    .use_falling (c_conv_fall),
    .bypass_sync (1'b1),
    .edge_pulse  (cnt_conv_edge)
  );

  assign conv_edge = (c_conv_src == `CONV_SRC_TIMEBASE) ? conv_div :
                     (c_conv_src == `CONV_SRC_COUNTER) ? cnt_conv_edge :
                     conv_ext_edge;
  assign conv_accept = conv_edge && in_sample;
  assign last_conv   = conv_accept &&
                       (conv_done + {{(NCH_W-1){1'b0}}, 1'b1} >= c_nch);

  // =====================================================================
  // Sample counter state machine
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_req)
          next_state = pretrigger_mode ? ST_PRE : ST_POST;
      end
      ST_PRE: begin
        if (pace_accept && samples_left <= 32'h0000_0001)
          next_state = ST_ARM;
      end
      ST_ARM: begin
        if (ref_edge)
          next_state = ST_POST;
      end
      ST_POST: begin
        // Last sample keeps its conversions before the run ends
        if (c_finite && samples_left == 32'h0000_0000 && !in_sample)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    if (sw_stop)
      next_state = ST_IDLE;
  end

  // =====================================================================
  // Configuration latch, counters and per-sample tracking
  always @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      c_pace_src <= `PACE_SRC_TIMEBASE;
      c_pace_idx <= 5'h00;
      c_pace_fall <= 1'b0;
      c_tb_src <= `TB_SRC_20MHZ;
      c_tb_idx <= 5'h00;
      c_tb_fall <= 1'b0;
      c_conv_src <= `CONV_SRC_TIMEBASE;
      c_conv_idx <= 5'h00;
      c_conv_fall <= 1'b0;
      c_conv_20 <= 1'b0;
      c_nch <= {{(NCH_W-1){1'b0}}, 1'b1};
      c_finite <= 1'b0;
      c_route <= `ROUTE_NONE;
      c_level <= 1'b0;
      acq_running <= 1'b0;
      in_sample <= 1'b0;
      conv_done <= {NCH_W{1'b0}};
      samples_left <= 32'h0000_0000;
      sample_start <= 1'b0;
      conversion_start <= 1'b0;
      start_pulse <= 1'b0;
      acq_done <= 1'b0;
      post_phase <= 1'b0;
    end else begin
      state <= next_state;
      sample_start <= pace_accept;
      conversion_start <= conv_accept;
      start_pulse <= start_req && start_is_software;
      acq_done <= (state != ST_IDLE) && (next_state == ST_IDLE);
      post_phase <= (next_state == ST_POST);
      if (state == ST_IDLE && !start_req) begin
        c_pace_src <= pace_src_sel;
        c_pace_idx <= pace_ext_index;
        c_pace_fall <= pace_falling;
        c_tb_src <= tb_src_sel;
        c_tb_idx <= tb_ext_index;
        c_tb_fall <= tb_falling;
        c_conv_src <= conv_src_sel;
        c_conv_idx <= conv_ext_index;
        c_conv_fall <= conv_falling;
        c_conv_20 <= conv_tb_is_20mhz;
        c_nch <= channel_count;
        c_finite <= finite_mode;
        c_route <= pace_route;
        c_level <= pace_level_mode;
      end
      acq_running <= (next_state != ST_IDLE);
      // Sample window
      if (next_state == ST_IDLE) begin
        in_sample <= 1'b0;
        conv_done <= {NCH_W{1'b0}};
      end else if (pace_accept) begin
        in_sample <= 1'b1;
        conv_done <= {NCH_W{1'b0}};
      end else if (last_conv) begin
        in_sample <= 1'b0;
        conv_done <= {NCH_W{1'b0}};
      end else if (conv_accept) begin
        conv_done <= conv_done + {{(NCH_W-1){1'b0}}, 1'b1};
      end
      // Sample counter
      if (start_req) begin
        samples_left <= pretrigger_mode ? pre_count : post_count;
      end else if (state == ST_ARM && ref_edge) begin
        samples_left <= post_count;
      end else if (pace_accept && samples_left != 32'h0000_0000) begin
        if (state == ST_PRE && samples_left == 32'h0000_0001)
          samples_left <= post_count;
        else if (state != ST_ARM)
          samples_left <= samples_left - 32'h0000_0001;
      end
    end
  end

  // =====================================================================
  // Output routing; pins stay inputs unless a route selects them
  always @(posedge clk) begin
    if (srst) begin
      pin_out  <= 16'h0000;
      pin_oe_n <= 16'hFFFF;
      bus_out  <= 8'h00;
      bus_oe_n <= 8'hFF;
    end else begin
      pin_out  <= 16'h0000;
      pin_oe_n <= 16'hFFFF;
      bus_out  <= 8'h00;
      bus_oe_n <= 8'hFF;
      if (c_route != `ROUTE_NONE) begin
        if (c_route[4]) begin
          bus_oe_n[c_route[2:0]] <= 1'b0;
          bus_out[c_route[2:0]]  <= c_level ? in_sample | pace_accept :
                                    pace_accept;
        end else begin
          pin_oe_n[c_route[3:0]] <= 1'b0;
          pin_out[c_route[3:0]]  <= c_level ? in_sample | pace_accept :
                                    pace_accept;
        end
      end
      if (start_route != `ROUTE_NONE && start_route != c_route) begin
        if (start_route[4]) begin
          bus_oe_n[start_route[2:0]] <= 1'b0;
          bus_out[start_route[2:0]]  <= start_req && start_is_software;
        end else begin
          pin_oe_n[start_route[3:0]] <= 1'b0;
          pin_out[start_route[3:0]]  <= start_req && start_is_software;
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: rtl/edge_pick.v
/*
  Edge picker: synchronises one asynchronous level through two flops
  unless bypass_sync is set, then emits a one-cycle pulse on the chosen edge.
  Assumes the input comes from outside the clk domain when bypass_sync is low.
*/
`default_nettype none

module edge_pick (
  input  wire clk,
  input  wire srst,
  input  wire level_in,
  input  wire use_falling,
  input  wire bypass_sync,
  output wire edge_pulse
);

  reg meta;
  reg sync;
  reg prev;
  wire cur;

  // =====================================================================
  // Synchroniser; first flop feeds only the second
  always @(posedge clk) begin
    if (srst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= level_in;
      sync <= meta;
      prev <= cur;
    end
  end

  // Internal sources are already on clk, so skip the sync stages
  assign cur = bypass_sync ? level_in : sync;
  assign edge_pulse = use_falling ? (prev & ~cur) : (~prev & cur);

endmodule

`default_nettype wire

// file: rtl/tick_divider.v
/*
  Programmable down-counter: after start it waits a first delay of
  timebase ticks, then pulses every period ticks while enabled.
  Assumes tick is a one-cycle pulse on clk.
*/
`default_nettype none

module tick_divider #(
  parameter WIDTH = 16
) (
  input  wire             clk,
  input  wire             srst,
  input  wire             start,
  input  wire             stop,
  input  wire             tick,
  input  wire [WIDTH-1:0] first_delay,
  input  wire [WIDTH-1:0] period,
  output reg              running,
  output reg              out_pulse
);

  reg [WIDTH-1:0] count;

  // =====================================================================
  // Count down on ticks; reload with period at each terminal count
  always @(posedge clk) begin
    if (srst) begin
      running   <= 1'b0;
      count     <= {WIDTH{1'b0}};
      out_pulse <= 1'b0;
    end else begin
      out_pulse <= 1'b0;
      if (stop) begin
        running <= 1'b0;
        count   <= first_delay;
      end else if (start) begin
        running <= 1'b1;
        count   <= first_delay;
      end else if (running && tick) begin
        if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          out_pulse <= 1'b1;
          count     <= period;
        end else begin
          count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

`default_nettype wire
